// file: rtl/ccgr_pkg.sv
package ccgr_pkg;
    // byte addresses of the bank
    localparam logic [7:0] ADDR_CTRL0   = 8'h00;
    localparam logic [7:0] ADDR_RSVD6   = 8'h06;
    localparam logic [7:0] ADDR_MAKER   = 8'h07;
    localparam logic [7:0] ADDR_PART    = 8'h08;
    localparam logic [7:0] ADDR_TEST    = 8'h09;
    localparam logic [7:0] ADDR_RSVD10  = 8'h0a;
    localparam logic [7:0] ADDR_RSVD11  = 8'h0b;
    localparam logic [7:0] ADDR_BLKLEN  = 8'h0c;
    localparam logic [7:0] ADDR_RSVD13  = 8'h0d;
    localparam logic [7:0] ADDR_VARIANT = 8'h0e;

    // fixed read values of reserved bytes and reserved bit groups
    localparam logic [7:0] RSVD6_VAL    = 8'h00;
    localparam logic [7:0] RSVD10_VAL   = 8'h03;
    localparam logic [7:0] RSVD11_VAL   = 8'h07;
    localparam logic [7:0] RSVD13_VAL   = 8'hfc;
    localparam logic [6:0] CTRL0_RSVD   = 7'h50;
    localparam logic [2:0] TEST_RSVD    = 3'h1;
    localparam logic [3:0] PART_RSVD    = 4'h0;
    localparam logic [2:0] VARIANT_RSVD = 3'h5;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;

    // field positions inside written bytes
    localparam int KEEP_BIT     = 0;
    localparam int TEST_SEL_BIT = 4;
    localparam int TEST_ENT_BIT = 3;
    localparam int SWING_MSB    = 2;

    // configuration held by the bank
    typedef struct packed {
        logic       keep;        // keep_config_on_sleep
        logic       test_sel;    // 1 = divided reference, 0 = high impedance
        logic       test_entry;  // 1 = test mode active
        logic [2:0] swing;       // swing_level
        logic [7:0] blk_len;     // last byte of a block read
    } ccgr_cfg_type;

    localparam ccgr_cfg_type CFG_RESET = '{keep: 1'b1, test_sel: 1'b0, test_entry: 1'b0,
                                           swing: 3'h5, blk_len: 8'h0f};

    // power sequencer states
    typedef enum logic [2:0] {
        ST_WAIT_GOOD = 3'b000,
        ST_RUN       = 3'b001,
        ST_STOPPING  = 3'b010,
        ST_HOLD_LOW  = 3'b011,
        ST_SLEEP     = 3'b100,
        ST_WAKE      = 3'b101,
        ST_ENABLE    = 3'b110
    } ccgr_state_type;

    // timing
    localparam int CLOCK_HZ        = 20_000_000;
    localparam int WAKE_LIMIT_US   = 1800;
    localparam int WAKE_LIMIT_CYC  = WAKE_LIMIT_US * (CLOCK_HZ / 1_000_000);
    localparam int REF_DIV         = 2;
    localparam int TEST_DIV        = 4;
    localparam int STOP_TICKS      = 2;
    localparam int ENABLE_TICKS    = 3;
    localparam int NUM_OUT         = 4;
endpackage

// file: rtl/ccgr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ccgr_regs #(
    parameter logic [3:0] REV_CODE     = 4'h3,   // arbitrary value
    parameter logic [3:0] MAKER_CODE   = 4'h6,   // arbitrary value
    parameter logic [3:0] PART_CODE    = 4'h9,   // arbitrary value
    parameter logic [4:0] VARIANT_CODE = 5'h0b,  // arbitrary value
    parameter int         WAKE_LIMIT_CYCLES = ccgr_pkg::WAKE_LIMIT_CYC
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    // byte register port
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    output logic [7:0]            reg_rdata_o,
    output logic                  reg_rvalid_o,
    // block read port
    input  wire logic             blk_start_i,
    input  wire logic             blk_next_i,
    output logic [7:0]            blk_data_o,
    output logic                  blk_valid_o,
    output logic                  blk_done_o,
    // shared power-good / sleep pin and analog status
    input  wire logic             supply_good_in_i,
    input  wire logic             pll_lock_i,
    // clock outputs and analog controls
    output logic [3:0]            clk_true_o,
    output logic [3:0]            clk_comp_o,
    output logic [3:0]            clk_oe_o,
    output logic [2:0]            swing_level_o,
    output logic                  osc_enable_o,
    output logic                  stable_o
);
    ccgr_pkg::ccgr_cfg_type   cfg;           // writable configuration
    ccgr_pkg::ccgr_state_type state;         // power sequencer state
    ccgr_pkg::ccgr_state_type next_state;
    logic                     pin_meta;      // first synchroniser stage
    logic                     pin_sync;      // synchronised pin level
    logic [1:0]               tick_cnt;      // reference divider
    logic                     ref_tick;      // one pulse per output edge
    logic                     ph;            // normal output phase
    logic [1:0]               test_cnt;      // divider for test clock
    logic                     test_ph;       // divided reference phase
    logic [1:0]               stop_cnt;      // edges seen with sleep low
    logic [1:0]               en_cnt;        // edges spent enabling
    logic [15:0]              wake_cnt;      // cycles since wake began
    logic [7:0]               blk_idx;       // next byte of block read
    logic [3:0]               next_true;
    logic [3:0]               next_comp;
    logic [3:0]               next_oe;

    // read value of any byte of the bank
    function automatic logic [7:0] read_byte(input logic [7:0] a,
                                             input ccgr_pkg::ccgr_cfg_type c);
        logic [7:0] v;
        v = ccgr_pkg::UNMAPPED_VAL;
        case (a)
            ccgr_pkg::ADDR_CTRL0:   v = {ccgr_pkg::CTRL0_RSVD, c.keep};
            ccgr_pkg::ADDR_RSVD6:   v = ccgr_pkg::RSVD6_VAL;
            ccgr_pkg::ADDR_MAKER:   v = {REV_CODE, MAKER_CODE};
            ccgr_pkg::ADDR_PART:    v = {PART_CODE, ccgr_pkg::PART_RSVD};
            ccgr_pkg::ADDR_TEST:    v = {ccgr_pkg::TEST_RSVD, c.test_sel, c.test_entry,
                                         c.swing};
            ccgr_pkg::ADDR_RSVD10:  v = ccgr_pkg::RSVD10_VAL;
            ccgr_pkg::ADDR_RSVD11:  v = ccgr_pkg::RSVD11_VAL;
            ccgr_pkg::ADDR_BLKLEN:  v = c.blk_len;
            ccgr_pkg::ADDR_RSVD13:  v = ccgr_pkg::RSVD13_VAL;
            ccgr_pkg::ADDR_VARIANT: v = {ccgr_pkg::VARIANT_RSVD, VARIANT_CODE};
            default:                v = ccgr_pkg::UNMAPPED_VAL;
        endcase
        return v;
    endfunction

    // decode of writes and sequencer conditions
    wire wr_ctrl0   = reg_wr_i && (reg_addr_i == ccgr_pkg::ADDR_CTRL0);
    wire wr_test    = reg_wr_i && (reg_addr_i == ccgr_pkg::ADDR_TEST);
    wire wr_blklen  = reg_wr_i && (reg_addr_i == ccgr_pkg::ADDR_BLKLEN);
    wire blk_more   = (blk_idx <= cfg.blk_len);
    wire clear_cfg  = (state == ccgr_pkg::ST_HOLD_LOW) && (next_state == ccgr_pkg::ST_SLEEP)
                      && !cfg.keep;
    wire tri_test   = cfg.test_entry && !cfg.test_sel;
    wire wake_limit = (wake_cnt >= 16'(WAKE_LIMIT_CYCLES - 1));
    wire stop_last  = ref_tick && !pin_sync && (stop_cnt == 2'(ccgr_pkg::STOP_TICKS - 1));
    wire en_last    = ref_tick && (en_cnt == 2'(ccgr_pkg::ENABLE_TICKS - 1));
    wire div_wrap   = (tick_cnt == 2'(ccgr_pkg::REF_DIV - 1));

    // two-stage synchroniser on the shared pin
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= supply_good_in_i;
            pin_sync <= pin_meta;
        end
    end

    // configuration writes; reserved and read-only bytes ignore writes
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg <= ccgr_pkg::CFG_RESET;
        end else if (clear_cfg) begin
            cfg <= ccgr_pkg::CFG_RESET;
        end else begin
            if (wr_ctrl0) begin
                cfg.keep <= reg_wdata_i[ccgr_pkg::KEEP_BIT];
            end
            if (wr_test) begin
                cfg.test_sel   <= reg_wdata_i[ccgr_pkg::TEST_SEL_BIT];
                cfg.test_entry <= reg_wdata_i[ccgr_pkg::TEST_ENT_BIT];
                cfg.swing      <= reg_wdata_i[ccgr_pkg::SWING_MSB:0];
            end
            if (wr_blklen) begin
                cfg.blk_len <= reg_wdata_i;
            end
        end
    end

    // single-byte reads
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= read_byte(reg_addr_i, cfg);
            end
        end
    end

    // block read walks bytes up to the length register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blk_idx     <= 8'h00;
            blk_data_o  <= 8'h00;
            blk_valid_o <= 1'b0;
            blk_done_o  <= 1'b0;
        end else begin
            blk_valid_o <= 1'b0;
            blk_done_o  <= 1'b0;
            if (blk_start_i) begin
                blk_idx <= reg_addr_i;
            end else if (blk_next_i && blk_more) begin
                blk_data_o  <= read_byte(blk_idx, cfg);
                blk_valid_o <= 1'b1;
                blk_idx     <= blk_idx + 8'h01;
            end else if (blk_next_i) begin
                blk_done_o <= 1'b1;
            end
        end
    end

    // reference divider and output phases
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt <= 2'h0;
            ref_tick <= 1'b0;
            ph       <= 1'b0;
            test_cnt <= 2'h0;
            test_ph  <= 1'b0;
        end else begin
            ref_tick <= div_wrap;
            tick_cnt <= div_wrap ? 2'h0 : tick_cnt + 2'h1; // tick period is REF_DIV cycles
            if (ref_tick) begin
                ph       <= !ph;
                test_cnt <= test_cnt + 2'h1;
                if (test_cnt == 2'(ccgr_pkg::TEST_DIV - 1)) begin
                    test_ph <= !test_ph;
                end
            end
        end
    end

    // power sequencer transitions
    always_comb begin
        next_state = state;
        case (state)
            ccgr_pkg::ST_WAIT_GOOD: if (pin_sync) next_state = ccgr_pkg::ST_WAKE;
            ccgr_pkg::ST_RUN:       if (!pin_sync) next_state = ccgr_pkg::ST_STOPPING;
            ccgr_pkg::ST_STOPPING: begin
                if (pin_sync) next_state = ccgr_pkg::ST_RUN;
                else if (stop_last) next_state = ccgr_pkg::ST_HOLD_LOW;
            end
            ccgr_pkg::ST_HOLD_LOW:  if (ref_tick) next_state = ccgr_pkg::ST_SLEEP;
            ccgr_pkg::ST_SLEEP:     if (pin_sync) next_state = ccgr_pkg::ST_WAKE;
            ccgr_pkg::ST_WAKE: begin
                if (!pin_sync) next_state = ccgr_pkg::ST_HOLD_LOW;
                else if (pll_lock_i || wake_limit) next_state = ccgr_pkg::ST_ENABLE;
            end
            ccgr_pkg::ST_ENABLE: begin
                if (!pin_sync) next_state = ccgr_pkg::ST_HOLD_LOW;
                else if (en_last) next_state = ccgr_pkg::ST_RUN;
            end
            default:                next_state = ccgr_pkg::ST_WAIT_GOOD;
        endcase
    end

    // sequencer state and its edge counters
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state    <= ccgr_pkg::ST_WAIT_GOOD;
            stop_cnt <= 2'h0;
            en_cnt   <= 2'h0;
            wake_cnt <= 16'h0000;
        end else begin
            state    <= next_state;
            stop_cnt <= (state != ccgr_pkg::ST_STOPPING) ? 2'h0
                        : (ref_tick ? stop_cnt + 2'h1 : stop_cnt);
            en_cnt   <= (state != ccgr_pkg::ST_ENABLE) ? 2'h0
                        : (ref_tick ? en_cnt + 2'h1 : en_cnt);
            wake_cnt <= (state != ccgr_pkg::ST_WAKE) ? 16'h0000 : wake_cnt + 16'h0001;
        end
    end

    // output levels per state
    always_comb begin
        next_true = '0;
        next_comp = '0;
        next_oe   = '1;
        case (state)
            ccgr_pkg::ST_RUN, ccgr_pkg::ST_STOPPING: begin
                if (tri_test) begin
                    next_oe = '0;
                end else begin
                    next_true = {ccgr_pkg::NUM_OUT{cfg.test_entry ? test_ph : ph}};
                    next_comp = ~next_true;
                end
            end
            ccgr_pkg::ST_WAKE:      next_true = '1;
            ccgr_pkg::ST_WAIT_GOOD: next_oe = '0;
            default: begin
                next_true = '0;
                next_comp = '0;
            end
        endcase
    end

    // registered pins
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            clk_true_o    <= 4'h0;
            clk_comp_o    <= 4'h0;
            clk_oe_o      <= 4'h0;
            swing_level_o <= ccgr_pkg::CFG_RESET.swing;
            osc_enable_o  <= 1'b1;
            stable_o      <= 1'b0;
        end else begin
            clk_true_o    <= next_true;
            clk_comp_o    <= next_comp;
            clk_oe_o      <= next_oe;
            swing_level_o <= cfg.swing;
            osc_enable_o  <= (state != ccgr_pkg::ST_SLEEP);
            stable_o      <= (state == ccgr_pkg::ST_RUN);
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    blk_stop_a: assert property (blk_next_i && !blk_start_i && !blk_more |=>
        blk_done_o && !blk_valid_o) else $error("block read ran past length");
    tri_state_a: assert property (state == ccgr_pkg::ST_RUN && tri_test |=>
        clk_oe_o == 4'h0) else $error("test tri-state not applied");
    normal_mode_a: assert property (state == ccgr_pkg::ST_RUN && !cfg.test_entry |=>
        clk_oe_o == 4'hf && clk_comp_o == ~clk_true_o) else $error("normal output wrong");
    swing_out_a: assert property (wr_test && !clear_cfg ##1 1'b1 |=>
        swing_level_o == $past(reg_wdata_i[2:0], 2)) else $error("swing not applied");
    maker_byte_a: assert property (reg_rd_i && reg_addr_i == ccgr_pkg::ADDR_MAKER |=>
        reg_rdata_o == {REV_CODE, MAKER_CODE}) else $error("maker byte wrong");
    variant_byte_a: assert property (reg_rd_i && reg_addr_i == ccgr_pkg::ADDR_VARIANT |=>
        reg_rdata_o[4:0] == VARIANT_CODE) else $error("variant code wrong");
    good_wait_a: assert property (state == ccgr_pkg::ST_WAIT_GOOD && !pin_sync |=>
        state == ccgr_pkg::ST_WAIT_GOOD && clk_oe_o == 4'h0) else $error("left power-good wait");
    sync_delay_a: assert property ($fell(supply_good_in_i) && state == ccgr_pkg::ST_RUN
        |=> state == ccgr_pkg::ST_RUN) else $error("pin used unsynchronised");
    low_before_off_a: assert property ($fell(osc_enable_o) |->
        $past(clk_true_o) == 4'h0 && $past(clk_comp_o) == 4'h0) else $error("osc off too early");
    two_edge_a: assert property (state == ccgr_pkg::ST_STOPPING && stop_last |=>
        ##1 clk_true_o == 4'h0 && clk_comp_o == 4'h0) else $error("outputs not held low");
    wake_bound_a: assert property (state == ccgr_pkg::ST_WAKE |->
        wake_cnt < 16'(WAKE_LIMIT_CYCLES)) else $error("wake exceeded limit");
    park_high_a: assert property (state == ccgr_pkg::ST_WAKE |=>
        clk_true_o == 4'hf && clk_oe_o == 4'hf) else $error("outputs not parked high");
    enable_run_a: assert property (state == ccgr_pkg::ST_ENABLE && en_last && pin_sync |=>
        state == ccgr_pkg::ST_RUN) else $error("enable did not finish");
    cfg_clear_a: assert property (clear_cfg |=>
        cfg == ccgr_pkg::CFG_RESET) else $error("config not cleared");
    part_byte_a: assert property (reg_rd_i && reg_addr_i == ccgr_pkg::ADDR_PART |=>
        reg_rdata_o == {PART_CODE, ccgr_pkg::PART_RSVD}) else $error("part byte wrong");
    rsvd_byte_a: assert property (reg_rd_i && reg_addr_i == ccgr_pkg::ADDR_RSVD13 |=>
        reg_rdata_o == ccgr_pkg::RSVD13_VAL) else $error("reserved byte wrong");

    sleep_entry_c: cover property (state == ccgr_pkg::ST_HOLD_LOW ##1
        state == ccgr_pkg::ST_SLEEP);
    wake_run_c: cover property (state == ccgr_pkg::ST_ENABLE ##1 state == ccgr_pkg::ST_RUN);
    test_clock_c: cover property (state == ccgr_pkg::ST_RUN && cfg.test_entry && cfg.test_sel);
    block_done_c: cover property (blk_done_o);
endmodule
`default_nettype wire

// file: verif/ccgr_power_host.sv
`timescale 1ns/1ps
`default_nettype none
// system power logic beside the clock block: shared pin and pll lock
module ccgr_power_host #(
    parameter int LOCK_CYCLES = 8  // pll settle time in cycles
) (
    // clock
    input  wire logic clock_i,
    // bench commands
    input  wire logic good_i,
    input  wire logic sleep_i,
    input  wire logic slow_i,
    // to the block
    output logic      pin_o,
    output logic      lock_o
);
    int cnt;  // cycles since pin went high

    // pin carries power good first, then active-low sleep; sleep only after good
    assign pin_o = good_i & ~sleep_i;

    // start with the pll unlocked
    initial begin
        cnt = 0;
        lock_o = 1'b0;
    end

    // lock follows the pin after the settle time; a slow pll never locks
    always @(posedge clock_i) begin
        #2;
        cnt = pin_o ? cnt + 1 : 0;
        lock_o = !slow_i && cnt >= LOCK_CYCLES;
    end
endmodule
`default_nettype wire

// file: verif/test_clockgen_ctrl_regs_powerdown.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITC(c, b) begin n = 0; while (!(c) && n < (b)) begin @(posedge clock_i); #2; n++; end \
    if (n >= (b)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, n, b); \
    conclude(); end end
module test_clockgen_ctrl_regs_powerdown;
    localparam logic [3:0] REV   = 4'h2;   // arbitrary value
    localparam logic [3:0] MAKER = 4'h5;   // arbitrary value
    localparam logic [3:0] PART  = 4'ha;   // arbitrary value
    localparam logic [4:0] VAR   = 5'h0c;  // arbitrary value
    // design ports
    logic       clock_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic       reg_rvalid_o;
    logic       blk_start_i = 1'b0;
    logic       blk_next_i = 1'b0;
    logic [7:0] blk_data_o;
    logic       blk_valid_o;
    logic       blk_done_o;
    logic       pin;
    logic       lock;
    logic [3:0] clk_true_o;
    logic [3:0] clk_comp_o;
    logic [3:0] clk_oe_o;
    logic [2:0] swing_level_o;
    logic       osc_enable_o;
    logic       stable_o;
    // power commands
    logic       good = 1'b0;
    logic       sleep = 1'b0;
    logic       slow = 1'b0;
    // bookkeeping and model
    int         err_count = 0;
    int         tests_run = 0;
    int         n;
    int         mr[16];          // register image
    logic [7:0] rnd = 8'h5a;     // lfsr state, seed 90
    logic [3:0] t0;
    int         lst[$] = '{6, 7, 8, 10, 11, 13, 14, 8'h40};

    ccgr_regs #(.REV_CODE(REV), .MAKER_CODE(MAKER), .PART_CODE(PART), .VARIANT_CODE(VAR),
        .WAKE_LIMIT_CYCLES(50)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .blk_start_i(blk_start_i), .blk_next_i(blk_next_i), .blk_data_o(blk_data_o),
        .blk_valid_o(blk_valid_o), .blk_done_o(blk_done_o), .supply_good_in_i(pin),
        .pll_lock_i(lock), .clk_true_o(clk_true_o), .clk_comp_o(clk_comp_o),
        .clk_oe_o(clk_oe_o), .swing_level_o(swing_level_o), .osc_enable_o(osc_enable_o),
        .stable_o(stable_o));
    ccgr_power_host host (.clock_i(clock_i), .good_i(good), .sleep_i(sleep), .slow_i(slow),
        .pin_o(pin), .lock_o(lock));

    // 20 mhz clock
    always #25 clock_i = ~clock_i;

    // next lfsr value
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // expected read value of an address
    function automatic logic [7:0] exp_rd(input int a);
        return (a < 16) ? 8'(mr[a]) : 8'h00;
    endfunction

    // power-up image of the bank
    task mreset();
        mr = '{default: 0};
        mr[0] = 8'ha1;
        mr[7] = {REV, MAKER};
        mr[8] = {PART, 4'h0};
        mr[9] = 8'h25;
        mr[10] = 8'h03;
        mr[11] = 8'h07;
        mr[12] = 8'h0f;
        mr[13] = 8'hfc;
        mr[14] = {3'h5, VAR};
    endtask

    // byte write, model keeps only writable fields
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #2 reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clock_i);
        #2 reg_wr_i = 1'b0;
        if (a == 8'h00) mr[0][0] = d[0];
        if (a == 8'h09) mr[9][4:0] = d[4:0];
        if (a == 8'h0c) mr[12] = d;
    endtask

    // byte read compared with the model
    task rd(input logic [7:0] a);
        @(posedge clock_i);
        #2 reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge clock_i);
        #2 reg_rd_i = 1'b0;
        `CHK({reg_rvalid_o, reg_rdata_o}, {1'b1, exp_rd(a)})
    endtask

    // block read from address a with cnt next requests, expecting done past the length
    task blk(input logic [7:0] a, input int cnt);
        int idx;
        idx = a;
        @(posedge clock_i);
        #2 blk_start_i = 1'b1;
        reg_addr_i = a;
        repeat (cnt) begin
            @(posedge clock_i);
            #2 blk_start_i = 1'b0;
            blk_next_i = 1'b1;
            @(posedge clock_i);
            #2 blk_next_i = 1'b0;
            if (idx <= mr[12]) begin
                `CHK({blk_valid_o, blk_done_o, blk_data_o}, {2'b10, exp_rd(idx)})
                idx++;
            end else begin
                `CHK({blk_valid_o, blk_done_o}, 2'b01)
            end
        end
    endtask

    // release the pin, expect outputs high, then running clocks
    task wake();
        good = 1'b1;
        sleep = 1'b0;
        `WAITC(clk_oe_o === 4'hf && clk_true_o === 4'hf, 20)
        `WAITC(stable_o === 1'b1, 150)
        t0 = clk_true_o;
        repeat (2) @(posedge clock_i);
        #2;
        `CHK({clk_oe_o, clk_true_o, clk_comp_o}, {4'hf, ~t0, t0})
    endtask

    // pull the pin low, outputs low before oscillators stop
    task do_sleep();
        sleep = 1'b1;
        `WAITC(clk_true_o === 4'h0 && clk_comp_o === 4'h0, 20)
        `WAITC(osc_enable_o === 1'b0, 20)
        `CHK({clk_true_o, clk_comp_o, stable_o}, 9'h000)
        if (mr[0][0] == 0) mreset();
    endtask

    // verdict and end of run
    task conclude();
        $display("errors=%0d checks=%0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        conclude();
    end

    // main sequence
    initial begin
        mreset();
        repeat (10) @(posedge clock_i);
        #2 reset_n_i = 1'b1;
        for (int a = 0; a < 17; a++) rd(8'(a));
        `CHK({swing_level_o, stable_o, clk_oe_o}, 8'ha0)
        foreach (lst[i]) begin
            rnd = lfsr(rnd);
            wr(8'(lst[i]), rnd);
            rd(8'(lst[i]));
        end
        repeat (6) begin
            rnd = lfsr(rnd);
            wr(8'h09, rnd);
            rd(8'h09);
            `CHK(swing_level_o, rnd[2:0])
            rnd = lfsr(rnd);
            wr(8'h0c, rnd);
            rd(8'h0c);
        end
        wr(8'h0c, 8'h0f);
        blk(8'h0d, 5);
        wr(8'h0c, 8'h10);
        blk(8'h0f, 3);
        wr(8'h09, 8'h05);
        wr(8'h00, 8'h01);
        wake();
        do_sleep();
        rd(8'h0c);
        slow = 1'b1;
        wake();
        wr(8'h09, 8'h0d);
        `WAITC(clk_oe_o === 4'h0, 10)
        wr(8'h09, 8'h1d);
        `WAITC(clk_oe_o === 4'hf, 10)
        t0 = clk_true_o;
        `WAITC(clk_true_o !== t0, 20)
        t0 = clk_true_o;
        `WAITC(clk_true_o !== t0, 20)
        `CHK(n, ccgr_pkg::TEST_DIV * ccgr_pkg::REF_DIV)
        wr(8'h09, 8'h05);
        wr(8'h00, 8'h00);
        wr(8'h0c, 8'h22);
        do_sleep();
        slow = 1'b0;
        wake();
        rd(8'h0c);
        rd(8'h00);
        conclude();
    end
endmodule
`default_nettype wire
